/* core/fsp_pkg.sv */
// shared constants for the flash self-programming sequencer
// assumes a single 25 MHz system clock and an 8-bit register port
package fsp_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_PTR_LO  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PTR_HI  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_DATA_LO = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_DATA_HI = 4'h4;

  // ----------------------------------------------------------------
  // control/status fields
  // ----------------------------------------------------------------
  localparam int BIT_EN    = 0;
  localparam int BIT_REEN  = 4;
  localparam int BIT_BUSY  = 6;
  localparam int BIT_IRQEN = 7;
  localparam int CMD_W     = 5;

  // low five bits of the control byte that arm a store-program
  localparam logic [CMD_W-1:0] CMD_LOAD  = 5'h01;
  localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
  localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
  localparam logic [CMD_W-1:0] CMD_LOCK  = 5'h09;
  localparam logic [CMD_W-1:0] CMD_REEN  = 5'h11;
  localparam logic [CMD_W-1:0] CMD_NONE  = 5'h00;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PTR_RST        = 16'h0000;
  localparam logic [7:0]  DATA_RST       = 8'h00;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
  localparam int          LOCK_W         = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          ARM_CYCLES    = 4;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PROG_TIME_NS  = 3700000;
  localparam int unsigned PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* core/fsp_page_buffer.sv */
// temporary page buffer: one word per location, write-once until cleared
// assumes clear and write never come in one cycle; clear drops the write
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buffer #(
  parameter int WORDS = 64,
  parameter int WIDTH = 16
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     clr_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(WORDS)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  input  wire logic [$clog2(WORDS)-1:0] raddr_i,
  output logic      [WIDTH-1:0]         rdata_o
);
  import fsp_pkg::*;

  logic [WIDTH-1:0] mem_q [WORDS];
  logic [WORDS-1:0] vld_q;

  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  // a loaded location refuses a second load until clear
  wire do_wr = we_i && !vld_q[waddr_i] && !clr_i;

  // valid map resets, so the buffer is empty after any reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vld_q <= '0;
    end else if (clr_i) begin
      vld_q <= '0;
    end else if (do_wr) begin
      vld_q[waddr_i] <= 1'b1;
    end
  end

  // data array carries no reset, only the valid map matters
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // unloaded words read as erased flash
  assign rdata_o = vld_q[raddr_i] ? mem_q[raddr_i] : WIDTH'(ERASED_WORD);

endmodule
`default_nettype wire

/* core/fsp_prog_timer.sv */
// programming duration counter, stands in for the oscillator-timed flash
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/1ps
`default_nettype none
module fsp_prog_timer #(
  parameter int unsigned CYCLES = fsp_pkg::PROG_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] cnt_q;

  // -------------------------------------------------------------
  // count down, done pulses in the last busy cycle
  // -------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= CNT_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy_o = (cnt_q != '0);
  assign done_o = (cnt_q == CNT_W'(1));

endmodule
`default_nettype wire

/* core/fsp_top.sv */
// flash self-programming sequencer: control register, pointer, page buffer
// assumes the core pulses SPM_EXEC_I/LPM_REQ_I and flash reads are async
//
// Overview of operation
// - reset vector is 0x0000 with fuse at 1, boot address with fuse at 0
// - fuse is input only; nothing the core does can change it
// - pointer low bits pick word in page, high bits pick the page
// - target page is latched when an operation starts
// - lock-bit set and re-enable ignore the pointer; all other operations use it
// - load-program reads pick the byte with pointer bit 0
// - X0000011 then store within four cycles erases the pointed page
// - erase keeps boot-safe readable; boot-safe erase halts the core
// - 00000001 then store loads data pair into buffer at word field
// - buffer clears after page write, on re-enable and on reset
// - an EEPROM write during loading discards the buffer contents
// - X0000101 then store writes buffer into the pointed page
// - write keeps boot-safe readable; boot-safe write halts the core
// - with interrupt enabled, request stays high while enable is clear
// - erase or write blocks updatable section and sets busy bit
// - re-enable command clears the busy bit after programming
// - X0001001 then store programs lock bits where data bits 5..0 are 0
// - lock programming blocks nothing and never halts the core
// - EEPROM write busy blocks every programming command
// - no store within four cycles clears command and enable, no action
// - busy bit reads one for as long as updatable reads are blocked
`timescale 1ns/1ps
`default_nettype none
module fsp_top #(
  parameter int          PAGE_WORDS      = 64,
  parameter int unsigned PROG_CYCLES     = fsp_pkg::PROG_CYCLES,
  parameter logic [14:0] BOOT_SAFE_START = 15'h1C00,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h1C00
) (
  input  wire logic                          SYS_CLK_I,
  input  wire logic                          ARST_N_I,
  input  wire logic [fsp_pkg::ADDR_W-1:0]    REG_ADDR_I,
  input  wire logic [fsp_pkg::DATA_W-1:0]    REG_WDATA_I,
  input  wire logic                          REG_WR_I,
  input  wire logic                          REG_RD_I,
  output logic      [fsp_pkg::DATA_W-1:0]    REG_RDATA_O,
  input  wire logic                          SPM_EXEC_I,
  input  wire logic                          LPM_REQ_I,
  input  wire logic                          EEPROM_WRITE_BUSY_I,
  input  wire logic                          BOOT_RESET_FUSE_I,
  input  wire logic [15:0]                   FLASH_RDATA_I,
  output logic      [15:0]                   RESET_VECTOR_O,
  output logic                               CPU_HALT_O,
  output logic                               UPD_READ_BLOCK_O,
  output logic                               SPM_IRQ_O,
  output logic      [14:0]                   FLASH_RADDR_O,
  output logic      [7:0]                    LPM_DATA_O,
  output logic                               LPM_VALID_O,
  output logic                               FLASH_ERASE_O,
  output logic                               FLASH_WRITE_O,
  output logic      [14:0]                   FLASH_PAGE_ADDR_O,
  output logic                               FLASH_WSTB_O,
  output logic      [$clog2(PAGE_WORDS)-1:0] FLASH_WIDX_O,
  output logic      [15:0]                   FLASH_WDATA_O,
  output logic                               FLASH_LOCK_O,
  output logic      [fsp_pkg::LOCK_W-1:0]    FLASH_LOCK_DATA_O
);
  import fsp_pkg::*;

  localparam int WIDX_W = $clog2(PAGE_WORDS);
  localparam logic [WIDX_W-1:0] WIDX_LAST = WIDX_W'(PAGE_WORDS - 1);
  localparam logic [1:0] ARM_LAST = 2'(ARM_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_PROG  = 3'b100
  } fsp_state_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // word address of the first word of the page the pointer names
  function automatic logic [14:0] page_base(input logic [15:0] z);
    page_base = z[15:1] & ~15'(PAGE_WORDS - 1);
  endfunction

  // pages at or above the boundary form the boot-safe section
  function automatic logic is_boot_safe(input logic [14:0] word_addr);
    is_boot_safe = (word_addr >= BOOT_SAFE_START);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fsp_state_e        st_q;
  logic [CMD_W-1:0]  cmd_q;
  logic [1:0]        arm_cnt_q;
  logic              irqen_q;
  logic              busy_q;
  logic [15:0]       ptr_q;
  logic [7:0]        data_lo_q;
  logic [7:0]        data_hi_q;
  logic              eep_q;
  logic              byte_sel_q;
  logic              lpm_pend_q;
  logic              str_act_q;
  logic [WIDX_W-1:0] str_cnt_q;
  logic [15:0]       buf_rdata;
  logic              tmr_done;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wr_ctrl    = REG_WR_I && (REG_ADDR_I == OFF_CTRL);
  wire wr_ptr_lo  = REG_WR_I && (REG_ADDR_I == OFF_PTR_LO);
  wire wr_ptr_hi  = REG_WR_I && (REG_ADDR_I == OFF_PTR_HI);
  wire wr_data_lo = REG_WR_I && (REG_ADDR_I == OFF_DATA_LO);
  wire wr_data_hi = REG_WR_I && (REG_ADDR_I == OFF_DATA_HI);
  wire [CMD_W-1:0] wr_cmd = REG_WDATA_I[CMD_W-1:0];

  // only the documented patterns arm; bit 7 is the interrupt enable
  wire cmd_valid = (wr_cmd == CMD_LOAD) || (wr_cmd == CMD_ERASE) ||
                   (wr_cmd == CMD_WRITE) || (wr_cmd == CMD_LOCK) ||
                   (wr_cmd == CMD_REEN);

  // an EEPROM write in flight refuses the command outright
  wire arm_ok = wr_ctrl && cmd_valid && (st_q == ST_IDLE) &&
                !EEPROM_WRITE_BUSY_I;

  // ---------------------------------------------------------------
  // store-program acceptance
  // ---------------------------------------------------------------
  wire spm_take = SPM_EXEC_I && (st_q == ST_ARMED) && !EEPROM_WRITE_BUSY_I;
  wire tk_load  = spm_take && (cmd_q == CMD_LOAD);
  wire tk_erase = spm_take && (cmd_q == CMD_ERASE);
  wire tk_write = spm_take && (cmd_q == CMD_WRITE);
  wire tk_lock  = spm_take && (cmd_q == CMD_LOCK);
  wire tk_reen  = spm_take && (cmd_q == CMD_REEN);
  wire tk_prog  = tk_erase || tk_write;
  wire arm_tout = (st_q == ST_ARMED) && !spm_take && (arm_cnt_q == ARM_LAST);

  // page field only; word field of the pointer is ignored here
  wire [14:0] tgt_page = page_base(ptr_q);
  wire        tgt_boot = is_boot_safe(tgt_page);

  // buffer is lost on write end, re-enable and EEPROM write start
  wire eep_rise = EEPROM_WRITE_BUSY_I && !eep_q;
  wire wr_done  = tmr_done && (cmd_q == CMD_WRITE);
  wire buf_clr  = tk_reen || wr_done || eep_rise;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // ops that hold enable set until the flash reports done
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_q      <= ST_IDLE;
      cmd_q     <= CMD_NONE;
      arm_cnt_q <= 2'h0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (arm_ok) begin
            st_q      <= ST_ARMED;
            cmd_q     <= wr_cmd;
            arm_cnt_q <= 2'h0;
          end
        end
        ST_ARMED: begin
          if (tk_prog || tk_lock) begin
            st_q <= ST_PROG;
          end else if (spm_take || arm_tout) begin
            st_q  <= ST_IDLE;
            cmd_q <= CMD_NONE;
          end else begin
            arm_cnt_q <= arm_cnt_q + 2'h1;
          end
        end
        ST_PROG: begin
          if (tmr_done) begin
            st_q  <= ST_IDLE;
            cmd_q <= CMD_NONE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // software-visible registers
  // ---------------------------------------------------------------
  // interrupt enable is writable even while a command is refused
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irqen_q <= 1'b0;
    end else if (wr_ctrl) begin
      irqen_q <= REG_WDATA_I[BIT_IRQEN];
    end
  end

  // pointer and data pair; a running op uses its own latched copy
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ptr_q     <= PTR_RST;
      data_lo_q <= DATA_RST;
      data_hi_q <= DATA_RST;
    end else begin
      if (wr_ptr_lo) ptr_q[7:0] <= REG_WDATA_I;
      if (wr_ptr_hi) ptr_q[15:8] <= REG_WDATA_I;
      if (wr_data_lo) data_lo_q <= REG_WDATA_I;
      if (wr_data_hi) data_hi_q <= REG_WDATA_I;
    end
  end

  // busy is the read block itself, so the two never disagree
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      busy_q <= 1'b0;
    end else if (tk_prog) begin
      busy_q <= 1'b1;
    end else if (tk_reen) begin
      busy_q <= 1'b0;
    end
  end
  assign UPD_READ_BLOCK_O = busy_q;

  // read mux, reserved bit 5 and unmapped offsets read zero
  wire [7:0] ctrl_rd = {irqen_q, busy_q, 1'b0, cmd_q};
  wire [7:0] rd_mux  = (REG_ADDR_I == OFF_CTRL)    ? ctrl_rd     :
                       (REG_ADDR_I == OFF_PTR_LO)  ? ptr_q[7:0]  :
                       (REG_ADDR_I == OFF_PTR_HI)  ? ptr_q[15:8] :
                       (REG_ADDR_I == OFF_DATA_LO) ? data_lo_q   :
                       (REG_ADDR_I == OFF_DATA_HI) ? data_hi_q   : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else begin
      REG_RDATA_O <= REG_RD_I ? rd_mux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // core-side outputs
  // ---------------------------------------------------------------
  // fuse is sampled, never stored or written back
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RESET_VECTOR_O <= APP_RESET_ADDR;
    end else begin
      RESET_VECTOR_O <= BOOT_RESET_FUSE_I ? APP_RESET_ADDR : BOOT_RESET_ADDR;
    end
  end

  // level request while enabled and no command stands
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SPM_IRQ_O <= 1'b0;
      eep_q     <= 1'b0;
    end else begin
      SPM_IRQ_O <= irqen_q && !cmd_q[BIT_EN];
      eep_q     <= EEPROM_WRITE_BUSY_I;
    end
  end

  // halt only for boot-safe erase/write, never for locks
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CPU_HALT_O <= 1'b0;
    end else if (tk_prog && tgt_boot) begin
      CPU_HALT_O <= 1'b1;
    end else if (tmr_done) begin
      CPU_HALT_O <= 1'b0;
    end
  end

  // byte-wide program reads; the word comes back the next cycle
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FLASH_RADDR_O <= 15'h0000;
      byte_sel_q    <= 1'b0;
      lpm_pend_q    <= 1'b0;
      LPM_DATA_O    <= 8'h00;
      LPM_VALID_O   <= 1'b0;
    end else begin
      lpm_pend_q  <= LPM_REQ_I;
      LPM_VALID_O <= lpm_pend_q;
      if (LPM_REQ_I) begin
        FLASH_RADDR_O <= ptr_q[15:1];
        byte_sel_q    <= ptr_q[0];
      end
      if (lpm_pend_q) begin
        LPM_DATA_O <= byte_sel_q ? FLASH_RDATA_I[15:8] : FLASH_RDATA_I[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // flash-side commands
  // ---------------------------------------------------------------
  // page latched at start, later pointer writes cannot move it
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FLASH_ERASE_O     <= 1'b0;
      FLASH_WRITE_O     <= 1'b0;
      FLASH_LOCK_O      <= 1'b0;
      FLASH_PAGE_ADDR_O <= 15'h0000;
      FLASH_LOCK_DATA_O <= '1;
    end else begin
      FLASH_ERASE_O <= tk_erase;
      FLASH_WRITE_O <= tk_write;
      FLASH_LOCK_O  <= tk_lock;
      if (tk_prog) begin
        FLASH_PAGE_ADDR_O <= tgt_page;
      end
      if (tk_lock) begin
        // pointer not consulted; 0 bits program their lock
        FLASH_LOCK_DATA_O <= data_lo_q[LOCK_W-1:0];
      end
    end
  end

  // page write streams every buffer word out once after the start
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      str_act_q <= 1'b0;
      str_cnt_q <= '0;
    end else if (tk_write) begin
      str_act_q <= 1'b1;
      str_cnt_q <= '0;
    end else if (str_act_q) begin
      str_act_q <= (str_cnt_q != WIDX_LAST);
      str_cnt_q <= str_cnt_q + 1'b1;
    end
  end

  // data pair is ignored here; only buffered words go out
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FLASH_WSTB_O  <= 1'b0;
      FLASH_WIDX_O  <= '0;
      FLASH_WDATA_O <= ERASED_WORD;
    end else begin
      FLASH_WSTB_O  <= str_act_q;
      FLASH_WIDX_O  <= str_cnt_q;
      FLASH_WDATA_O <= buf_rdata;
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  // load writes the data pair at the pointer word field
  fsp_page_buffer #(
    .WORDS (PAGE_WORDS),
    .WIDTH (16)
  ) u_buf (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (ARST_N_I),
    .clr_i   (buf_clr),
    .we_i    (tk_load),
    .waddr_i (ptr_q[WIDX_W:1]),
    .wdata_i ({data_hi_q, data_lo_q}),
    .raddr_i (str_cnt_q),
    .rdata_o (buf_rdata)
  );

  // one duration for erase, write and lock programming
  fsp_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_tmr (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (ARST_N_I),
    .start_i (tk_prog || tk_lock),
    .busy_o  (),
    .done_o  (tmr_done)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_arm;
    arm_ok;
  endsequence

  sequence s_quiet_window;
    (!SPM_EXEC_I)[*4];
  endsequence

  sequence s_take_prog;
    tk_prog;
  endsequence

  a_arm_timeout: assert property (s_arm ##1 s_quiet_window |=>
      (st_q == ST_IDLE) && !cmd_q[BIT_EN])
    else $error("armed command did not time out after four cycles");

  a_irq_level: assert property ((irqen_q && !cmd_q[BIT_EN]) |=> SPM_IRQ_O)
    else $error("store-program request missing while enable clear");

  a_prog_blocks: assert property (s_take_prog |=> UPD_READ_BLOCK_O && busy_q)
    else $error("erase or write did not block the updatable section");

  a_busy_holds: assert property ((busy_q && !tk_reen) |=> busy_q)
    else $error("busy bit dropped without re-enable");

  a_reen_clears: assert property (tk_reen |=> !busy_q ##1 !busy_q)
    else $error("re-enable did not clear busy");

  a_boot_halt: assert property ((tk_prog && tgt_boot) |=>
      CPU_HALT_O throughout (st_q == ST_PROG)[*2])
    else $error("boot-safe programming did not halt the core");

  a_lock_free: assert property (tk_lock && !busy_q && !CPU_HALT_O |=>
      (!UPD_READ_BLOCK_O && !CPU_HALT_O)[*3])
    else $error("lock programming blocked reads or halted the core");

  a_eeprom_refuse: assert property ((wr_ctrl && EEPROM_WRITE_BUSY_I &&
      st_q == ST_IDLE) |=> st_q == ST_IDLE)
    else $error("command armed during an EEPROM write");

  a_page_latched: assert property ((st_q == ST_PROG && $past(st_q) == ST_PROG)
      |-> $stable(FLASH_PAGE_ADDR_O))
    else $error("programming page changed mid operation");

  // the first sample after reset still shows the reset value, so skip it
  a_reset_vector: assert property ($past(ARST_N_I) && !$past(BOOT_RESET_FUSE_I) |->
      RESET_VECTOR_O == BOOT_RESET_ADDR)
    else $error("reset vector ignores programmed fuse");

endmodule
`default_nettype wire

/* tb/fsp_cpu_model.sv */
// core model: pulses the store strobe some cycles after a control write
// assumes the bench sets the spacing before each control write
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [2:0] gap_i,
  output logic            spm_o
);
  logic [2:0] cnt_q;
  wire        ctl_wr = wr_i && addr_i == fsp_pkg::OFF_CTRL;
  // gap 1..4 keeps the arming window, 0 never strobes, 5 is one cycle late
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      spm_o <= 1'b0;
    end else begin
      spm_o <= ctl_wr ? gap_i == 3'd1 : cnt_q == 3'd2;
      cnt_q <= ctl_wr ? gap_i : cnt_q - {2'b00, cnt_q != 3'd0};
    end
  end
endmodule
`default_nettype wire

/* tb/flash_self_programming_tb_top.sv */
// bench: int model of the page buffer, compared at every page-write word strobe
// assumes the core model issues the store strobe after control writes
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module flash_self_programming_tb_top;
  import fsp_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, lpm = 0, ee = 0, fuse = 1;
  logic        spm, halt, blk, irq, lv, fer, wstb, flk, fwr;
  int          nwe = 0;
  logic [2:0]  gap = 0;
  logic [3:0]  addr = 0;
  logic [5:0]  widx, lkd;
  logic [7:0]  wd = 0, rdat, ldat, lcap, d;
  logic [8:0]  pg;
  logic [14:0] fra, fpa;
  logic [15:0] vec, fwd, ptr;
  logic [31:0] rs = 32'd60647;
  int          mismatches = 0, num_checks = 0, nw = 0, ner = 0, nlk = 0, nlv = 0, bufm[64];
  always #20 clk = ~clk;
  fsp_cpu_model u_core (.clk_i(clk), .rst_n_i(rst_n), .wr_i(wr), .addr_i(addr), .gap_i(gap),
    .spm_o(spm));
  fsp_top #(.PROG_CYCLES(80)) u_dut (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .SPM_EXEC_I(spm),
    .LPM_REQ_I(lpm), .EEPROM_WRITE_BUSY_I(ee), .BOOT_RESET_FUSE_I(fuse),
    .FLASH_RDATA_I({1'b0, fra} ^ 16'h5a3c), .RESET_VECTOR_O(vec), .CPU_HALT_O(halt),
    .UPD_READ_BLOCK_O(blk), .SPM_IRQ_O(irq), .FLASH_RADDR_O(fra), .LPM_DATA_O(ldat),
    .LPM_VALID_O(lv), .FLASH_ERASE_O(fer), .FLASH_WRITE_O(fwr), .FLASH_PAGE_ADDR_O(fpa),
    .FLASH_WSTB_O(wstb), .FLASH_WIDX_O(widx), .FLASH_WDATA_O(fwd), .FLASH_LOCK_O(flk),
    .FLASH_LOCK_DATA_O(lkd));
  // sampled on the falling edge so registered outputs have settled
  always @(negedge clk) begin
    if (fer) ner++;
    if (flk) nlk++;
    if (fwr) nwe++;
    if (lv) begin nlv++; lcap = ldat; end
    if (wstb) begin
      nw++;
      `CHK("wdata", 16'(bufm[widx]), fwd)
      `CHK("wpage", {pg, 6'h00}, fpa)
    end
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13); rs = rs ^ (rs >> 17); rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wd <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0; #1;
  endtask
  task automatic setp(input logic [15:0] p);
    ptr = p; wr_reg(OFF_PTR_LO, p[7:0]); wr_reg(OFF_PTR_HI, p[15:8]);
  endtask
  // bench keeps the EEPROM idle before control writes unless a refusal is meant
  task automatic op(input logic [7:0] c, input logic [2:0] g);
    gap <= g; wr_reg(OFF_CTRL, c);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic idle();
    for (int i = 0; i < 90; i++) begin rd_reg(OFF_CTRL); if (rdat[BIT_EN] === 1'b0) return; end
    mismatches++; complete_run();
  endtask
  task automatic wt(ref int c, input int n);
    for (int i = 0; i < 99 && c < n; i++) @(negedge clk);
    if (c < n) begin mismatches++; complete_run(); end
  endtask
  task automatic load(input logic [5:0] w, input logic [15:0] v, input logic [2:0] g);
    setp({pg, w, 1'b0}); wr_reg(OFF_DATA_LO, v[7:0]); wr_reg(OFF_DATA_HI, v[15:8]);
    op(8'h01, g); bufm[w] = v; idle(); rd_reg(OFF_CTRL);
    `CHK("ctrl", 8'h00, rdat)
  endtask
  task automatic pgwr(input logic [2:0] g);
    nw = 0; nwe = 0; setp({pg, 7'h00}); op(8'h05, g); wt(nw, 1);
    `CHK("halt", pg == 9'h070, halt)
    idle(); `CHK("words", 64, nw)
    `CHK("wpulse", 1, nwe)
    foreach (bufm[i]) bufm[i] = 32'h0000_ffff; // buffer empties after a page write
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    foreach (bufm[i]) bufm[i] = 32'h0000_ffff;
    repeat (5) @(posedge clk); rst_n <= 1'b1; @(negedge clk);
    `CHK("vec", APP_RESET_ADDR, vec)
    @(posedge clk); fuse <= 1'b0; repeat (2) @(negedge clk);
    `CHK("vec", 16'h1c00, vec)
    @(posedge clk); fuse <= 1'b1; pg = 9'(rnd() % 112);
    for (int k = 0; k < 4; k++) load(6'(k * 16 + rnd() % 16), 16'(rnd()), 3'(k + 1));
    setp({pg, 7'h00}); op(8'h03, 3'd2); setp(16'(rnd())); @(negedge clk);
    `CHK("epage", {pg, 6'h00}, fpa)
    `CHK("blk", 2'b10, {blk, halt})
    rd_reg(OFF_CTRL); `CHK("busy", 1'b1, rdat[BIT_BUSY])
    idle(); `CHK("erase", 1, ner)
    pgwr(3'd3); pg = 9'h070; pgwr(3'd4);
    op(8'h11, 3'd1); idle(); rd_reg(OFF_CTRL);
    `CHK("reen", 9'h000, {blk, rdat})
    wr_reg(OFF_CTRL, 8'h80); repeat (2) @(negedge clk); `CHK("irq", 1'b1, irq)
    d = 8'(rnd()) | 8'hc0; setp(16'h0001); wr_reg(OFF_DATA_LO, d);
    op(8'h89, 3'd4); wt(nlk, 1);
    `CHK("lock", {d[5:0], 3'b000}, {lkd, irq, blk, halt})
    idle(); @(negedge clk); `CHK("irq", 1'b1, irq)
    op(8'h03, 3'd5); repeat (8) @(negedge clk); rd_reg(OFF_CTRL);
    `CHK("late", {8'h00, 32'd1}, {rdat, ner})
    pg = 9'(rnd() % 112); load(6'(rnd()), 16'(rnd()), 3'd1);
    @(posedge clk); ee <= 1'b1;
    foreach (bufm[i]) bufm[i] = 32'h0000_ffff; // EEPROM write discards the buffer
    op(8'h01, 3'd1); rd_reg(OFF_CTRL); `CHK("eebusy", 8'h00, rdat)
    @(posedge clk); ee <= 1'b0; pgwr(3'd2);
    for (int b = 0; b < 2; b++) begin
      setp({15'(rnd()), b[0]}); @(posedge clk); lpm <= 1'b1; @(posedge clk); lpm <= 1'b0;
      wt(nlv, b + 1);
      d = ptr[0] ? 8'(({1'b0, ptr[15:1]} ^ 16'h5a3c) >> 8) : 8'(ptr[15:1] ^ 15'h5a3c);
      `CHK("lpm", d, lcap)
    end
    complete_run();
  end
endmodule
`default_nettype wire
